// file: ssm_defines.svh
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH

// register byte offsets
`define SSM_OFS_CTRL_HIGH 8'h00
`define SSM_OFS_CTRL_LOW  8'h04
`define SSM_OFS_MODE      8'h08
`define SSM_OFS_ENABLE    8'h0C
`define SSM_OFS_STATUS    8'h10
`define SSM_OFS_CTRL2     8'h14
`define SSM_OFS_TXDATA    8'h18
`define SSM_OFS_RXDATA    8'h1C
`define SSM_OFS_IRQ       8'h20

// serial_control_high fields
`define SSM_MSS_BIT  7
`define SSM_BIDIRECTIONAL_MODE_BIT 6
`define SSM_SOL_BIT  4
`define SSM_OUTPUT_LEVEL_WRITE_BIT 3
// serial_control_low fields
`define SSM_FCLR_BIT 7
`define SSM_UMS_BIT  6
`define SSM_SEQUENCER_RESET_BIT 5
// serial_mode fields
`define SSM_ORDER_BIT 7
`define SSM_CPOL_BIT  6
`define SSM_CPHA_BIT  5
// serial_enable fields
`define SSM_TE_BIT   7
`define SSM_RE_BIT   6
`define SSM_TRANSMIT_END_IRQ_ENABLE_BIT 3
`define SSM_TIE_BIT  2
`define SSM_RIE_BIT  1
`define SSM_CONFLICT_IRQ_ENABLE_BIT 0
// serial_status fields
`define SSM_OVERRUN_FLAG_BIT 6
`define SSM_TRANSMIT_END_FLAG_BIT 3
`define SSM_TRANSMIT_EMPTY_FLAG_BIT 2
`define SSM_RECEIVE_FULL_FLAG_BIT 1
`define SSM_CE_BIT   0
// control 2 field
`define SSM_TRANSMIT_END_TIMING_BIT 4

// reset values
`define SSM_RST_CTRL_HIGH 8'h84
`define SSM_RST_CTRL_LOW  8'h00
`define SSM_RST_MODE      8'h00
`define SSM_RST_ENABLE    8'h00
`define SSM_RST_CTRL2     8'h00

// chip-select automatic mode
`define SSM_CSS_AUTO 2'h3

`endif

// file: ssm_pkg.sv
package ssm_pkg;
	typedef enum logic [1:0] {
		SSM_IDLE  = 2'b00,
		SSM_LEAD  = 2'b01,
		SSM_SHIFT = 2'b11,
		SSM_LAG   = 2'b10
	} ssm_state_t;

	typedef enum logic [1:0] {
		SSM_LEN8  = 2'b00,
		SSM_LEN16 = 2'b01,
		SSM_LEN32 = 2'b10,
		SSM_LENX  = 2'b11
	} ssm_len_t;
endpackage

// file: ssm_clkdiv.sv
`timescale 1ns/1ps
// half-period tick generator for the serial clock; divide = 2 << select
module ssm_clkdiv
	import ssm_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// control
	input  wire logic       run,
	input  wire logic [2:0] select,
	// half-period tick
	output logic            half_tick
);
	logic [8:0] count;
	wire  [8:0] half_count = 9'(9'h001 << select) - 9'h001;
	wire        wrap       = (count >= half_count);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count     <= 9'h000;
			half_tick <= 1'b0;
		end else if (!run) begin
			count     <= 9'h000;
			half_tick <= 1'b0;
		end else begin
			count     <= wrap ? 9'h000 : count + 9'h001;
			half_tick <= wrap;
		end
	end
endmodule

// file: ssm_sync_serial_master.sv
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_sync_serial_master
	import ssm_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// serial pins
	output logic             serial_clock,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	input  wire logic        serial_data_in,
	output logic             chip_select_pin_n,
	output logic             chip_select_oe,
	// interrupt requests
	output logic             transmit_end_irq,
	output logic             transmit_empty_irq,
	output logic             receive_full_irq,
	output logic             overrun_irq,
	output logic             conflict_irq
);
	// registers
	logic [7:0]  serial_control_high;
	logic [7:0]  serial_control_low;
	logic [7:0]  serial_mode;
	logic [7:0]  serial_enable;
	logic [7:0]  serial_control2;
	logic [31:0] transmit_data_register;
	logic [31:0] receive_data_register;
	logic [31:0] shift_register;
	logic        transmit_end_flag;
	logic        transmit_empty_flag;
	logic        receive_full_flag;
	logic        overrun_flag;
	logic        conflict_flag;
	// read-before-clear memory for status flags
	logic        seen_overrun_flag;
	logic        seen_transmit_end_flag;
	logic        seen_transmit_empty_flag;
	logic        seen_receive_full_flag;
	logic        seen_ce;
	// ahb address phase capture
	logic        ap_valid;
	logic        ap_write;
	logic [7:0]  ap_addr;
	// sequencer
	ssm_state_t  state;
	logic [5:0]  bit_count;
	logic        clk_phase;
	logic        tx_active;
	logic        rx_active;
	logic [1:0]  din_sync;
	logic        data_out;

	// bus decode
	wire addr_phase = hsel && htrans[1] && hready;
	wire wr_en      = ap_valid && ap_write;
	wire rd_en      = ap_valid && !ap_write;
	wire [7:0] wdat = hwdata[7:0];
	wire wr_ch   = wr_en && ap_addr == `SSM_OFS_CTRL_HIGH;
	wire wr_cl   = wr_en && ap_addr == `SSM_OFS_CTRL_LOW;
	wire wr_md   = wr_en && ap_addr == `SSM_OFS_MODE;
	wire wr_en_r = wr_en && ap_addr == `SSM_OFS_ENABLE;
	wire wr_st   = wr_en && ap_addr == `SSM_OFS_STATUS;
	wire wr_c2   = wr_en && ap_addr == `SSM_OFS_CTRL2;
	wire wr_td   = wr_en && ap_addr == `SSM_OFS_TXDATA;
	wire rd_st   = addr_phase && !hwrite && haddr[7:0] == `SSM_OFS_STATUS;
	wire rd_rd   = rd_en && ap_addr == `SSM_OFS_RXDATA;

	// control fields
	wire        te       = serial_enable[`SSM_TE_BIT];
	wire        re       = serial_enable[`SSM_RE_BIT];
	wire        flag_clear_mode    = serial_control_low[`SSM_FCLR_BIT];
	wire        cpol     = serial_mode[`SSM_CPOL_BIT];
	wire        cpha     = serial_mode[`SSM_CPHA_BIT];
	wire        msb_1st  = serial_mode[`SSM_ORDER_BIT];
	wire [2:0]  cks      = serial_mode[2:0];
	wire [1:0]  css      = serial_control_high[1:0];
	wire        transmit_end_timing  = serial_control2[`SSM_TRANSMIT_END_TIMING_BIT];
	wire        sequencer_reset     = wr_cl && wdat[`SSM_SEQUENCER_RESET_BIT];
	ssm_len_t   len;
	assign len = ssm_len_t'(serial_control_low[1:0]);

	function automatic logic [5:0] len_bits(input ssm_len_t l);
		unique case (l)
			SSM_LEN16: len_bits = 6'd16;
			SSM_LEN32: len_bits = 6'd32;
			default:   len_bits = 6'd8;
		endcase
	endfunction

	function automatic logic flag_clear(input logic wr, input logic seen,
			input logic bitval);
		flag_clear = wr && seen && !bitval;
	endfunction

	wire [5:0] nbits    = len_bits(len);
	wire       half_tick;
	wire       running  = (state != SSM_IDLE);
	wire       can_start = !running && ((te && !transmit_empty_flag) ||
			(re && !te && !receive_full_flag));
	wire       lead_edge  = half_tick && !clk_phase;
	wire       trail_edge = half_tick && clk_phase;
	wire       last_bit   = (bit_count == nbits - 6'd1);
	wire       sample_edge = cpha ? lead_edge : trail_edge;
	wire       change_edge = cpha ? trail_edge : lead_edge;
	wire       word_done  = (state == SSM_SHIFT) && trail_edge && last_bit;
	wire       rx_done    = word_done && rx_active;
	wire [31:0] shift_in  = msb_1st ? {shift_register[30:0], din_sync[1]} :
			{din_sync[1], shift_register[31:1]};
	// phase 1 has already taken its last bit on the leading edge
	wire [31:0] rx_word   = cpha ? shift_register : shift_in;
	wire [31:0] lsb_word  = msb_1st ? rx_word : 32'(rx_word >> (6'd32 - nbits));
	wire [5:0]  top_idx   = nbits - 6'd1;
	wire        out_bit   = msb_1st ? shift_register[top_idx[4:0]] : shift_register[0];
	wire        transmit_end_flag_set  = transmit_empty_flag && tx_active &&
			(transmit_end_timing ? (state == SSM_LAG && half_tick) : word_done);

	// status flag clear terms: zero written after the flag was read as one, plus data-register accesses for three flags
	wire clr_overrun_flag = flag_clear(wr_st, seen_overrun_flag, wdat[`SSM_OVERRUN_FLAG_BIT]);
	wire clr_transmit_end_flag = flag_clear(wr_st, seen_transmit_end_flag, wdat[`SSM_TRANSMIT_END_FLAG_BIT]) || wr_td;
	wire clr_transmit_empty_flag = flag_clear(wr_st, seen_transmit_empty_flag, wdat[`SSM_TRANSMIT_EMPTY_FLAG_BIT]) ||
			(wr_td && te && flag_clear_mode);
	wire clr_receive_full_flag = flag_clear(wr_st, seen_receive_full_flag, wdat[`SSM_RECEIVE_FULL_FLAG_BIT]) ||
			(rd_rd && flag_clear_mode);
	wire clr_ce   = flag_clear(wr_st, seen_ce, wdat[`SSM_CE_BIT]);

	wire [7:0] status = {1'b0, overrun_flag, 2'b00, transmit_end_flag,
			transmit_empty_flag, receive_full_flag, conflict_flag};

	logic [31:0] next_rdata;
	always_comb begin
		unique case (haddr[7:0])
			`SSM_OFS_CTRL_HIGH: next_rdata = {24'h0, serial_control_high};
			`SSM_OFS_CTRL_LOW:  next_rdata = {24'h0, serial_control_low};
			`SSM_OFS_MODE:      next_rdata = {24'h0, serial_mode};
			`SSM_OFS_ENABLE:    next_rdata = {24'h0, serial_enable};
			`SSM_OFS_STATUS:    next_rdata = {24'h0, status};
			`SSM_OFS_CTRL2:     next_rdata = {24'h0, serial_control2};
			`SSM_OFS_TXDATA:    next_rdata = transmit_data_register;
			`SSM_OFS_RXDATA:    next_rdata = receive_data_register;
			default:            next_rdata = 32'h0000_0000;
		endcase
	end

	ssm_clkdiv u_clkdiv (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.run       (running),
		.select    (cks),
		.half_tick (half_tick)
	);

	// ahb-lite: zero wait states, always okay; read data registered from address phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ap_valid  <= 1'b0;
			ap_write  <= 1'b0;
			ap_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_valid <= addr_phase;
			ap_write <= hwrite;
			ap_addr  <= haddr[7:0];
			if (addr_phase && !hwrite)
				hrdata <= next_rdata;
		end
	end

	// control registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_control_high <= `SSM_RST_CTRL_HIGH;
			serial_control_low  <= `SSM_RST_CTRL_LOW;
			serial_mode         <= `SSM_RST_MODE;
			serial_enable       <= `SSM_RST_ENABLE;
			serial_control2     <= `SSM_RST_CTRL2;
		end else begin
			if (wr_ch)
				serial_control_high <= {wdat[7:6], 1'b0, wdat[4], 1'b0, 1'b1, wdat[1:0]};
			if (wr_cl)
				serial_control_low <= {wdat[7:6], 4'h0, wdat[1:0]}; // sequencer reset self-clears
			if (wr_md)
				serial_mode <= {wdat[7:5], 2'b00, wdat[2:0]};
			if (wr_en_r)
				serial_enable <= {wdat[7:6], 2'b00, wdat[3:0]};
			if (wr_c2)
				serial_control2 <= {3'b000, wdat[4:0]};
		end
	end

	// status flags: a set in the same cycle as a clear wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			transmit_end_flag   <= 1'b1;
			transmit_empty_flag <= 1'b1;
			receive_full_flag   <= 1'b0;
			overrun_flag        <= 1'b0;
			conflict_flag       <= 1'b0;
			seen_overrun_flag <= 1'b0;
			seen_transmit_end_flag <= 1'b0;
			seen_transmit_empty_flag <= 1'b0;
			seen_receive_full_flag <= 1'b0;
			seen_ce   <= 1'b0;
			transmit_data_register <= 32'h0000_0000;
			receive_data_register  <= 32'h0000_0000;
		end else begin
			if (rd_st) begin
				seen_overrun_flag <= overrun_flag;
				seen_transmit_end_flag <= transmit_end_flag;
				seen_transmit_empty_flag <= transmit_empty_flag;
				seen_receive_full_flag <= receive_full_flag;
				seen_ce   <= conflict_flag;
			end
			if (wr_td)
				transmit_data_register <= hwdata;
			if (rx_done && receive_full_flag)
				overrun_flag <= 1'b1;
			else if (clr_overrun_flag)
				overrun_flag <= 1'b0;
			if (rx_done && !receive_full_flag) begin
				receive_data_register <= lsb_word;
				receive_full_flag     <= 1'b1;
			end else if (clr_receive_full_flag) begin
				receive_full_flag <= 1'b0;
			end
			if (!te || (can_start && te))
				transmit_empty_flag <= 1'b1;
			else if (clr_transmit_empty_flag || (wr_td && te && !flag_clear_mode))
				transmit_empty_flag <= 1'b0;
			if (transmit_end_flag_set)
				transmit_end_flag <= 1'b1;
			else if (clr_transmit_end_flag)
				transmit_end_flag <= 1'b0;
			if (wr_td && running && tx_active)
				conflict_flag <= 1'b1;
			else if (clr_ce)
				conflict_flag <= 1'b0;
		end
	end

	// transfer sequencer; master mode generates its own clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state       <= SSM_IDLE;
			bit_count   <= 6'd0;
			clk_phase   <= 1'b0;
			tx_active   <= 1'b0;
			rx_active   <= 1'b0;
			shift_register <= 32'h0000_0000;
			din_sync    <= 2'b00;
			data_out    <= 1'b0;
		end else begin
			din_sync <= {din_sync[0], serial_data_in};
			if (wr_ch && wdat[`SSM_OUTPUT_LEVEL_WRITE_BIT])
				data_out <= wdat[`SSM_SOL_BIT];
			if (sequencer_reset) begin
				state     <= SSM_IDLE;
				bit_count <= 6'd0;
				clk_phase <= 1'b0;
			end else begin
				unique case (state)
					SSM_IDLE: if (can_start) begin
						state     <= SSM_LEAD;
						tx_active <= te;
						rx_active <= re;
						shift_register <= transmit_data_register;
						bit_count <= 6'd0;
						clk_phase <= 1'b0;
					end
					SSM_LEAD: if (half_tick) begin
						state <= SSM_SHIFT;
						if (cpha && tx_active)
							data_out <= out_bit;
					end
					SSM_SHIFT: if (half_tick) begin
						clk_phase <= !clk_phase;
						// one register serves both ways: MSB first, out at the top and in at the bottom; LSB first, the reverse
						if (sample_edge)
							shift_register <= shift_in;
						if (trail_edge) begin
							bit_count <= bit_count + 6'd1;
							if (last_bit)
								state <= SSM_LAG;
						end
					end
					SSM_LAG: if (half_tick)
						state <= SSM_IDLE;
				endcase
				if (state == SSM_SHIFT && change_edge && tx_active && !(cpha && last_bit))
					data_out <= out_bit;
			end
		end
	end

	// pin and request outputs, all registered
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_clock       <= 1'b1;
			serial_data_out    <= 1'b0;
			serial_data_oe     <= 1'b0;
			chip_select_pin_n  <= 1'b1;
			chip_select_oe     <= 1'b0;
			transmit_end_irq   <= 1'b0;
			transmit_empty_irq <= 1'b0;
			receive_full_irq   <= 1'b0;
			overrun_irq        <= 1'b0;
			conflict_irq       <= 1'b0;
		end else begin
			// polarity 0: idle high, pulses low while active
			serial_clock <= ((state == SSM_SHIFT) && (clk_phase ^ half_tick)) ? cpol : !cpol;
			serial_data_out   <= data_out;
			serial_data_oe    <= te;
			chip_select_oe    <= (css == `SSM_CSS_AUTO);
			chip_select_pin_n <= !((css == `SSM_CSS_AUTO) && running);
			transmit_end_irq   <= serial_enable[`SSM_TRANSMIT_END_IRQ_ENABLE_BIT] && transmit_end_flag;
			transmit_empty_irq <= serial_enable[`SSM_TIE_BIT] && transmit_empty_flag;
			receive_full_irq   <= serial_enable[`SSM_RIE_BIT] && receive_full_flag;
			overrun_irq        <= serial_enable[`SSM_RIE_BIT] && overrun_flag;
			conflict_irq       <= serial_enable[`SSM_CONFLICT_IRQ_ENABLE_BIT] && conflict_flag;
		end
	end
endmodule

// file: ssm_eeprom_model.sv
`timescale 1ns/1ps
// serial memory stand-in: shifts a fixed reply out and records what it is sent
module ssm_eeprom_model #(
	parameter logic [31:0] REPLY = 32'hC35A96E1
) (
	// serial pins
	input  wire logic   serial_clock,
	input  wire logic   chip_select_pin_n,
	input  wire logic   serial_data_out,
	output logic        serial_data_in,
	// observation
	output logic [31:0] got,
	output int          falls
);
	logic [31:0] reply_sr;
	initial begin
		serial_data_in = 1'b0;
		got = 32'h0;
		falls = 0;
	end
	always @(negedge chip_select_pin_n) begin
		reply_sr = REPLY;
		got = 32'h0;
		falls = 0;
	end
	// idle-high clock, phase 0: drive on the falling edge, capture on the rising one
	always @(negedge serial_clock) begin
		if (!chip_select_pin_n) begin
			serial_data_in = reply_sr[31];
			reply_sr = reply_sr << 1;
			falls++;
		end
	end
	always @(posedge serial_clock) begin
		if (!chip_select_pin_n) got = {got[30:0], serial_data_out};
	end
	// a released line must not keep showing the last bit
	always @(posedge chip_select_pin_n) serial_data_in = ~serial_data_in;
endmodule

// file: ssm_sync_serial_master_checker.sv
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_sync_serial_master_checker (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// register bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	// serial pins
	input wire logic        serial_clock,
	input wire logic        serial_data_out,
	input wire logic        chip_select_pin_n,
	input wire logic        chip_select_oe,
	// requests
	input wire logic        transmit_end_irq,
	input wire logic        transmit_empty_irq,
	input wire logic        receive_full_irq,
	input wire logic        overrun_irq,
	input wire logic        conflict_irq
);
	logic       en_wr;
	logic [7:0] en;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// shadow of the enable register so gating is judged from the pins alone
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_wr <= 1'b0;
			en    <= 8'h00;
		end else if (hready) begin
			en_wr <= hsel && htrans[1] && hwrite && haddr[7:0] == `SSM_OFS_ENABLE;
			if (en_wr) en <= hwdata[7:0];
		end
	end
	sequence s_low_half;
		!serial_clock [*8] ##1 serial_clock;
	endsequence
	sequence s_lead;
		serial_clock [*8] ##1 serial_clock [*8] ##1 !serial_clock;
	endsequence
	AST_CLK_IDLE: assert property (chip_select_pin_n [*3] |-> serial_clock)
		else $error("clock not idle high");
	AST_HALF_PERIOD: assert property (disable iff (rst || chip_select_pin_n)
		$fell(serial_clock) |-> s_low_half) else $error("low half not 8 cycles");
	AST_CS_LEAD: assert property ($fell(chip_select_pin_n) |-> s_lead)
		else $error("select lead wrong");
	AST_DATA_HOLD: assert property ($rose(serial_clock) && !chip_select_pin_n
		|-> $stable(serial_data_out)) else $error("data moved on capture edge");
	AST_CS_OE: assert property (!chip_select_oe |-> chip_select_pin_n)
		else $error("select low while not driven");
	AST_TEI: assert property (!en[3] && !$past(en[3]) |-> !transmit_end_irq)
		else $error("end request while disabled");
	AST_TXI: assert property (!en[2] && !$past(en[2]) |-> !transmit_empty_irq)
		else $error("empty request while disabled");
	AST_RXI: assert property (!en[1] && !$past(en[1])
		|-> !receive_full_irq && !overrun_irq) else $error("receive request while disabled");
	AST_CEI: assert property (!en[0] && !$past(en[0]) |-> !conflict_irq)
		else $error("conflict request while disabled");
endmodule
bind ssm_sync_serial_master ssm_sync_serial_master_checker i_ssm_sync_serial_master_checker (
	.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .serial_clock,
	.serial_data_out, .chip_select_pin_n, .chip_select_oe, .transmit_end_irq,
	.transmit_empty_irq, .receive_full_irq, .overrun_irq, .conflict_irq);

// file: ssm_sync_serial_master_bench.sv
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_sync_serial_master_bench;
	import ssm_pkg::*;
	localparam logic [31:0] REPLY = 32'hC35A96E1;
	localparam logic [7:0]  ST    = `SSM_OFS_STATUS;
	localparam logic [7:0]  TX    = `SSM_OFS_TXDATA;
	logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, got, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        serial_clock, serial_data_out, serial_data_oe, serial_data_in;
	logic        chip_select_pin_n, chip_select_oe, transmit_end_irq, transmit_empty_irq;
	logic        receive_full_irq, overrun_irq, conflict_irq;
	int          errors, num_checks, falls;
	assign hready = hreadyout;
	ssm_sync_serial_master i_ssm_sync_serial_master (.sys_clk, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .serial_clock,
		.serial_data_out, .serial_data_oe, .serial_data_in, .chip_select_pin_n,
		.chip_select_oe, .transmit_end_irq, .transmit_empty_irq, .receive_full_irq,
		.overrun_irq, .conflict_irq);
	ssm_eeprom_model #(.REPLY(REPLY)) i_ssm_eeprom_model (.serial_clock, .chip_select_pin_n,
		.serial_data_out, .serial_data_in, .got, .falls);
	always #12.5 sys_clk = ~sys_clk;
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hold();
		int n;
		for (n = 0; n == 0 || (hready !== 1'b1 && n < 100); n++) @(posedge sys_clk);
		if (n >= 100) begin
			errors++;
			final_report();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		hold();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hold();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask
	task automatic wait_cs(input logic lvl, input int lim);
		int n;
		for (n = 0; n < lim && chip_select_pin_n !== lvl; n++) @(posedge sys_clk);
		if (n >= lim) begin
			errors++;
			final_report();
		end
	endtask
	task automatic run(input logic [31:0] d);
		wr(TX, d);
		wait_cs(1'b0, 100);
		wait_cs(1'b1, 1500);
	endtask
	task automatic t_reset();
		rdc(`SSM_OFS_CTRL_HIGH, 32'hFF, 32'h84);
		rdc(`SSM_OFS_ENABLE, 32'hFF, 32'h00);
		rdc(ST, 32'hFF, 32'h0C);
		rdc(8'h40, 32'hFFFFFFFF, 32'h0);
		check(serial_clock, 1'b1);
	endtask
	task automatic t_level();
		wr(`SSM_OFS_CTRL_HIGH, 32'h8F);
		repeat (2) @(posedge sys_clk);
		check(serial_data_out, 1'b0);
		wr(`SSM_OFS_CTRL_HIGH, 32'h9F);
		repeat (2) @(posedge sys_clk);
		check(serial_data_out, 1'b1);
		check(chip_select_oe, 1'b1);
	endtask
	task automatic t_len();
		int          nb;
		logic [31:0] m, d;
		wr(`SSM_OFS_MODE, 32'h83);
		wr(`SSM_OFS_ENABLE, 32'hC0);
		for (int l = 0; l < 3; l++) begin
			nb = 8 << l;
			m = 32'hFFFFFFFF >> (32 - nb);
			d = 32'h9B2DE671 + l;
			wr(`SSM_OFS_CTRL_LOW, 32'h80 | l);
			run(d);
			check(got & m, d & m);
			check(falls, nb);
			check(serial_data_oe, 1'b1);
			rdc(ST, 32'h0E, 32'h0E);
			rdc(`SSM_OFS_RXDATA, m, REPLY >> (32 - nb));
			rdc(ST, 32'h02, 32'h00);
		end
	endtask
	task automatic t_irq();
		run(32'h12345678);
		check({transmit_end_irq, transmit_empty_irq, receive_full_irq}, 3'h0);
		wr(`SSM_OFS_ENABLE, 32'hCE);
		repeat (2) @(posedge sys_clk);
		check({transmit_end_irq, transmit_empty_irq, receive_full_irq}, 3'h7);
		check(conflict_irq, 1'b0);
		run(32'h0F0F0F0F);
		rdc(ST, 32'h4A, 32'h4A);
		check(overrun_irq, 1'b1);
		wr(ST, 32'h04);
		rdc(ST, 32'h4A, 32'h00);
		run(32'hA5A55A5A);
		wr(TX, 32'h3C3CC3C3);
		rdc(ST, 32'h08, 32'h00);
		wait_cs(1'b0, 100);
		wait_cs(1'b1, 1500);
	endtask
	task automatic t_inhibit();
		wr(`SSM_OFS_ENABLE, 32'h00);
		wr(TX, 32'h55);
		repeat (100) @(posedge sys_clk);
		check(chip_select_pin_n, 1'b1);
		check(serial_data_oe, 1'b0);
		bus(1'b0, `SSM_OFS_RXDATA, 32'h0);
		wr(`SSM_OFS_CTRL2, 32'h10);
		wr(`SSM_OFS_ENABLE, 32'h80);
		run(32'h00C0FFEE);
		rdc(ST, 32'h0A, 32'h08);
	endtask
	task automatic t_sequencer_reset();
		wr(TX, 32'hFFFF0000);
		wait_cs(1'b0, 100);
		repeat (40) @(posedge sys_clk);
		wr(`SSM_OFS_CTRL_LOW, 32'hA2);
		wait_cs(1'b1, 20);
		check(falls < 32, 1'b1);
	endtask
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_level();
		t_len();
		t_irq();
		t_inhibit();
		t_sequencer_reset();
		final_report();
	end
endmodule
